// ---- pkg/event_status_pkg.sv ----
// shared constants and types for the event timestamp status block
package event_status_pkg;
    localparam int          UNITS       = 8;
    localparam int          LOST_WIDTH  = 3;
    localparam logic [4:0]  STATUS_ADDR = 5'h1e;
    localparam logic [4:0]  DATA_ADDR   = 5'h1f;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam int          LOST_LSB    = 8;
    localparam int          LEN_LSB     = 6;
    localparam int          DIR_BIT     = 5;
    localparam int          UNIT_LSB    = 2;
    localparam int          MULT_BIT    = 1;
    localparam int          PRESENT_BIT = 0;
    localparam logic [2:0]  LOST_MAX    = 3'h7;
    localparam int          NS_WIDTH    = 30;
    localparam int          SEC_WIDTH   = 32;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] ext;
        logic [63:0] stamp;
    } entry_type;

    typedef enum logic [2:0] {
        WORD_EXT    = 3'b000,
        WORD_NS_LO  = 3'b001,
        WORD_NS_HI  = 3'b010,
        WORD_SEC_LO = 3'b011,
        WORD_SEC_HI = 3'b100
    } data_word_type;
endpackage : event_status_pkg

// ---- pkg/status_build_if.sv ----
// carrier between the queue and the status word builder
`timescale 1ns/10ps
interface status_build_if;
    logic [7:0]  detected;
    logic [7:0]  rising;
    logic [23:0] missed;
    logic [63:0] new_stamp;
    logic [63:0] prev_stamp;
    logic [15:0] status;
    logic [15:0] ext;

    modport builder (
        input  detected,
        input  rising,
        input  missed,
        input  new_stamp,
        input  prev_stamp,
        output status,
        output ext
    );
    modport user (
        output detected,
        output rising,
        output missed,
        output new_stamp,
        output prev_stamp,
        input  status,
        input  ext
    );
endinterface : status_build_if

// ---- rtl/event_timestamp_status.sv ----
// event timestamp capture queue with status and event data read ports
`timescale 1ns/10ps
module event_timestamp_status #(
    parameter int DEPTH = 4
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clock_enable,
    input  wire logic        reg_read,
    input  wire logic [4:0]  reg_addr,
    input  wire logic        capture_valid,
    input  wire logic [7:0]  capture_detected,
    input  wire logic [7:0]  capture_rising,
    input  wire logic [31:0] capture_seconds,
    input  wire logic [29:0] capture_nanoseconds,
    output logic      [15:0] read_data,
    output logic             entry_pending
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    event_status_pkg::entry_type     mem [DEPTH];
    event_status_pkg::entry_type     next_mem [DEPTH];
    event_status_pkg::entry_type     cur;
    event_status_pkg::entry_type     next_cur;
    event_status_pkg::entry_type     new_entry;
    event_status_pkg::data_word_type word_sel;
    event_status_pkg::data_word_type next_word_sel;
    logic [PW-1:0]                   rd_ptr;
    logic [PW-1:0]                   next_rd_ptr;
    logic [PW-1:0]                   wr_ptr;
    logic [PW-1:0]                   next_wr_ptr;
    logic [CW-1:0]                   count;
    logic [CW-1:0]                   next_count;
    logic [63:0]                     prev_stamp;
    logic [63:0]                     next_prev_stamp;
    logic [63:0]                     stamp_in;
    logic [23:0]                     missed;
    logic [15:0]                     next_read_data;
    logic                            next_entry_pending;
    logic                            status_read;
    logic                            data_read;
    logic                            push_try;
    logic                            accept;
    logic                            pop;

    status_build_if sb ();

    status_word_builder u_builder (
        .port (sb.builder)
    );

    assign stamp_in      = {capture_seconds, 2'b00, capture_nanoseconds};
    assign sb.detected   = capture_detected;
    assign sb.rising     = capture_rising;
    assign sb.missed     = missed;
    assign sb.new_stamp  = stamp_in;
    assign sb.prev_stamp = prev_stamp;
    assign new_entry     = '{status: sb.status, ext: sb.ext, stamp: stamp_in};

    // address decode of the management read
    always_comb begin
        status_read = 1'b0;
        data_read   = 1'b0;
        if (reg_read && reg_addr == event_status_pkg::STATUS_ADDR) begin
            status_read = 1'b1;
        end else if (reg_read && reg_addr == event_status_pkg::DATA_ADDR) begin
            data_read = 1'b1;
        end
    end

    assign push_try = capture_valid && capture_detected != 8'h00;
    assign pop      = status_read && count != CW'(0);
    // a full queue still takes a capture when the head leaves in the same cycle
    assign accept   = push_try && (count != CW'(DEPTH) || pop);

    always_comb begin
        next_mem           = mem;
        next_cur           = cur;
        next_rd_ptr        = rd_ptr;
        next_wr_ptr        = wr_ptr;
        next_count         = count;
        next_prev_stamp    = prev_stamp;
        if (accept) begin
            next_mem[wr_ptr] = new_entry;
            next_wr_ptr      = (wr_ptr == PW'(DEPTH - 1)) ? PW'(0) : PW'(wr_ptr + PW'(1));
            next_prev_stamp  = stamp_in;
        end
        if (pop) begin
            next_cur    = mem[rd_ptr];
            next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? PW'(0) : PW'(rd_ptr + PW'(1));
        end else if (status_read) begin
            next_cur = '0;
        end
        if (accept && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !accept) begin
            next_count = count - CW'(1);
        end
        next_entry_pending = next_count != CW'(0);
    end

    // read port: answer register and data word pointer
    always_comb begin
        next_word_sel  = word_sel;
        next_read_data = read_data;
        if (status_read) begin
            next_read_data = next_cur.status;
            next_word_sel  = next_cur.status[event_status_pkg::MULT_BIT] ? event_status_pkg::WORD_EXT
                                                                          : event_status_pkg::WORD_NS_LO;
        end else if (data_read) begin
            // fixed word order, wraps to the low word
            case (word_sel)
                event_status_pkg::WORD_EXT: begin
                    next_read_data = cur.ext;
                    next_word_sel  = event_status_pkg::WORD_NS_LO;
                end
                event_status_pkg::WORD_NS_LO: begin
                    next_read_data = cur.stamp[15:0];
                    next_word_sel  = event_status_pkg::WORD_NS_HI;
                end
                event_status_pkg::WORD_NS_HI: begin
                    next_read_data = cur.stamp[31:16];
                    next_word_sel  = event_status_pkg::WORD_SEC_LO;
                end
                event_status_pkg::WORD_SEC_LO: begin
                    next_read_data = cur.stamp[47:32];
                    next_word_sel  = event_status_pkg::WORD_SEC_HI;
                end
                default: begin
                    next_read_data = cur.stamp[63:48];
                    next_word_sel  = event_status_pkg::WORD_NS_LO;
                end
            endcase
        end else if (reg_read) begin
            // other addresses belong elsewhere; answer zero
            next_read_data = 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            cur           <= '0;
            rd_ptr        <= '0;
            wr_ptr        <= '0;
            count         <= '0;
            prev_stamp    <= 64'h0;
            entry_pending <= 1'b0;
        end else if (clock_enable) begin
            mem           <= next_mem;
            cur           <= next_cur;
            rd_ptr        <= next_rd_ptr;
            wr_ptr        <= next_wr_ptr;
            count         <= next_count;
            prev_stamp    <= next_prev_stamp;
            entry_pending <= next_entry_pending;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            word_sel  <= event_status_pkg::WORD_NS_LO;
            read_data <= event_status_pkg::STATUS_RESET;
        end else if (clock_enable) begin
            word_sel  <= next_word_sel;
            read_data <= next_read_data;
        end
    end

    generate
        for (genvar u = 0; u < event_status_pkg::UNITS; u++) begin : g_lost
            logic [event_status_pkg::LOST_WIDTH-1:0] lost;
            logic [event_status_pkg::LOST_WIDTH-1:0] next_lost;

            always_comb begin
                next_lost = lost;
                if (push_try && capture_detected[u]) begin
                    if (accept) begin
                        // only the reported unit's count reaches the accepted entry; start over anyway
                        next_lost = '0;
                    end else if (lost != event_status_pkg::LOST_MAX) begin
                        // saturates; seven means seven or more
                        next_lost = lost + 3'h1;
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    lost <= '0;
                end else if (clock_enable) begin
                    lost <= next_lost;
                end
            end

            assign missed[event_status_pkg::LOST_WIDTH*u +: event_status_pkg::LOST_WIDTH] = lost;
        end
    endgenerate
endmodule : event_timestamp_status

// ---- rtl/status_word_builder.sv ----
// builds the status word and extended per-unit word of one capture
`timescale 1ns/10ps
module status_word_builder (
    status_build_if.builder port
);
    logic [2:0] low_det;
    logic [2:0] low_lost;
    logic       any_lost;
    logic [2:0] sel;
    logic [1:0] length;

    genvar g;
    generate
        for (g = 0; g < event_status_pkg::UNITS; g++) begin : g_unit
            assign port.ext[2*g]   = port.detected[g];
            assign port.ext[2*g+1] = port.detected[g] & port.rising[g];
        end
    endgenerate

    always_comb begin
        low_det  = 3'h0;
        low_lost = 3'h0;
        any_lost = 1'b0;
        for (int i = event_status_pkg::UNITS - 1; i >= 0; i--) begin
            if (port.detected[i]) begin
                low_det = 3'(i);
            end
            if (port.detected[i] && port.missed[3*i +: 3] != 3'h0) begin
                low_lost = 3'(i);
                any_lost = 1'b1;
            end
        end
        sel = any_lost ? low_lost : low_det;
        // highest changed word, counted from the low end
        if (port.new_stamp[63:48] != port.prev_stamp[63:48]) begin
            length = 2'h3;
        end else if (port.new_stamp[47:32] != port.prev_stamp[47:32]) begin
            length = 2'h2;
        end else if (port.new_stamp[31:16] != port.prev_stamp[31:16]) begin
            length = 2'h1;
        end else begin
            length = 2'h0;
        end
        port.status = event_status_pkg::STATUS_RESET;
        // loss count of the reported unit
        port.status[event_status_pkg::LOST_LSB +: 3] = port.missed[3*sel +: 3];
        port.status[event_status_pkg::LEN_LSB +: 2] = length;
        port.status[event_status_pkg::DIR_BIT] = port.rising[sel];
        port.status[event_status_pkg::UNIT_LSB +: 3] = sel;
        port.status[event_status_pkg::MULT_BIT] = (port.detected & (port.detected - 8'h01)) != 8'h00;
        port.status[event_status_pkg::PRESENT_BIT] = |port.detected;
    end
endmodule : status_word_builder

// ---- verification/event_timestamp_status_chk.sv ----
// assertion checker for the event timestamp status block
`timescale 1ns/10ps
module event_timestamp_status_chk #(
    parameter int DEPTH = 4
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        clock_enable,
    input wire logic        reg_read,
    input wire logic [4:0]  reg_addr,
    input wire logic        capture_valid,
    input wire logic [7:0]  capture_detected,
    input wire logic [7:0]  capture_rising,
    input wire logic [31:0] capture_seconds,
    input wire logic [29:0] capture_nanoseconds,
    input wire logic [15:0] read_data,
    input wire logic        entry_pending
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence stat_rd;
        reg_read && clock_enable && reg_addr == event_status_pkg::STATUS_ADDR;
    endsequence
    sequence data_rd;
        reg_read && clock_enable && reg_addr == event_status_pkg::DATA_ADDR;
    endsequence
    reserved_zero_a: assert property (stat_rd |=> read_data[15:11] == 5'h00)
        else $error("status reserved bits set");
    empty_status_a: assert property (stat_rd ##0 !entry_pending |=> read_data == 16'h0000)
        else $error("empty queue gave nonzero status");
    present_bit_a: assert property (stat_rd ##0 entry_pending |=> read_data[0])
        else $error("queued entry without present bit");
    // extended word must name at least two units
    ext_word_a: assert property (stat_rd ##1 (read_data[1] && !reg_read) ##1 data_rd
        |=> $countones(read_data & 16'h5555) >= 2) else $error("extended word lacks units");
    capture_queued_a: assert property ((capture_valid && clock_enable && capture_detected != 8'h00)
        |=> entry_pending) else $error("capture not queued");
    frozen_state_a: assert property (!clock_enable |=> $stable(read_data) && $stable(entry_pending))
        else $error("state moved while disabled");
    read_hold_a: assert property (!(reg_read && clock_enable) |=> $stable(read_data))
        else $error("read data changed without read");
    unmapped_zero_a: assert property ((reg_read && clock_enable && reg_addr != 5'h1e
        && reg_addr != 5'h1f) |=> read_data == 16'h0000) else $error("unmapped read nonzero");
endmodule : event_timestamp_status_chk

// ---- verification/event_timestamp_status_test.sv ----
// self-checking bench for the event timestamp status block
`timescale 1ns/10ps
module event_timestamp_status_test;
    localparam int DEPTH = 2;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        clock_enable = 1'b1;
    logic        reg_read = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic        capture_valid = 1'b0;
    logic [7:0]  capture_detected = 8'h00;
    logic [7:0]  capture_rising = 8'h00;
    logic [31:0] capture_seconds = 32'h0;
    logic [29:0] capture_nanoseconds = 30'h0;
    logic [15:0] read_data;
    logic        entry_pending;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #20 clock = ~clock;

    event_timestamp_status #(.DEPTH(DEPTH)) dut_u (
        .clock(clock), .rst(rst), .clock_enable(clock_enable), .reg_read(reg_read), .reg_addr(reg_addr),
        .capture_valid(capture_valid), .capture_detected(capture_detected), .capture_rising(capture_rising),
        .capture_seconds(capture_seconds), .capture_nanoseconds(capture_nanoseconds),
        .read_data(read_data), .entry_pending(entry_pending));

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one read, judged against the expected answer
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(read_data, exp);
    endtask : rdc

    task automatic cap(input logic [7:0] det, input logic [7:0] rise, input logic [31:0] sec,
                       input logic [29:0] ns);
        @(posedge clock);
        capture_valid <= 1'b1;
        capture_detected <= det;
        capture_rising <= rise;
        capture_seconds <= sec;
        capture_nanoseconds <= ns;
        @(posedge clock);
        capture_valid <= 1'b0;
    endtask : cap

    function automatic logic [15:0] st(input int lost, input int len, input int dir, input int unit,
                                       input int mult);
        return 16'((lost << 8) | (len << 6) | (dir << 5) | (unit << 2) | (mult << 1) | 1);
    endfunction : st

    // four timestamp words, low nanoseconds first
    task automatic words(input logic [63:0] w);
        for (int i = 0; i < 4; i++) begin
            rdc(5'h1f, w[16*i +: 16]);
        end
    endtask : words

    task automatic test_empty;
        rdc(5'h1e, 16'h0000);
        rdc(5'h1f, 16'h0000);
        rdc(5'h05, 16'h0000);
    endtask : test_empty

    task automatic test_single;
        cap(8'h08, 8'h08, 32'h0000_0001, 30'h2abc_1234);
        #1 check(16'(entry_pending), 16'h0001);
        @(posedge clock);
        clock_enable <= 1'b0;
        // a read while disabled must not advance the queue
        rdc(5'h1e, 16'h0000);
        @(posedge clock);
        clock_enable <= 1'b1;
        rdc(5'h1e, st(0, 2, 1, 3, 0));
        words(64'h0000_0001_2abc_1234);
        rdc(5'h1f, 16'h1234);
        rdc(5'h1e, 16'h0000);
    endtask : test_single

    task automatic test_multi;
        cap(8'ha4, 8'ha0, 32'h0000_0001, 30'h2abc_5678);
        rdc(5'h1e, st(0, 0, 0, 2, 1));
        rdc(5'h1f, 16'hcc10);
        rdc(5'h1f, 16'h5678);
    endtask : test_multi

    // queue of two filled, then losses pile up past saturation
    task automatic test_loss;
        repeat (2) cap(8'h01, 8'h00, 32'h0000_0001, 30'h2abc_5678);
        repeat (9) cap(8'h12, 8'h12, 32'h0000_0001, 30'h2abc_5678);
        repeat (2) rdc(5'h1e, st(0, 0, 0, 0, 0));
        cap(8'h13, 8'h02, 32'h0001_0001, 30'h2abc_5678);
        rdc(5'h1e, st(7, 3, 1, 1, 1));
        rdc(5'h1f, 16'h010d);
        words(64'h0001_0001_2abc_5678);
        cap(8'h10, 8'h00, 32'h0001_0001, 30'h2abc_5678);
        rdc(5'h1e, st(0, 0, 0, 4, 0));
    endtask : test_loss

    // zero masks and captures while frozen must not queue
    task automatic test_ignored;
        cap(8'h00, 8'h00, 32'h0000_0000, 30'h0000_0000);
        @(posedge clock);
        clock_enable <= 1'b0;
        cap(8'h01, 8'h01, 32'h0000_0000, 30'h0000_0000);
        @(posedge clock);
        clock_enable <= 1'b1;
        #1 check(16'(entry_pending), 16'h0000);
        rdc(5'h1e, 16'h0000);
    endtask : test_ignored

    // full queue takes a capture when the head leaves together
    task automatic test_full_pop;
        cap(8'h40, 8'h00, 32'h0001_0001, 30'h2abd_5678);
        cap(8'h80, 8'h80, 32'h0001_0001, 30'h2abd_5678);
        fork
            rdc(5'h1e, st(0, 1, 0, 6, 0));
            cap(8'h01, 8'h01, 32'h0001_0001, 30'h2abd_5679);
        join
        rdc(5'h1e, st(0, 0, 1, 7, 0));
        rdc(5'h1e, st(0, 0, 1, 0, 0));
        check(16'(entry_pending), 16'h0000);
        rdc(5'h1e, 16'h0000);
    endtask : test_full_pop

    // mid-run reset empties the queue and the reference stamp
    task automatic test_reset;
        repeat (2) cap(8'h02, 8'h02, 32'h0000_0005, 30'h0000_0007);
        rdc(5'h1e, st(0, 3, 1, 1, 0));
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1 check(read_data, 16'h0000);
        check(16'(entry_pending), 16'h0000);
        rdc(5'h1f, 16'h0000);
        rdc(5'h1e, 16'h0000);
        cap(8'h02, 8'h02, 32'h0000_0005, 30'h0000_0007);
        rdc(5'h1e, st(0, 2, 1, 1, 0));
    endtask : test_reset

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        test_empty();
        test_single();
        test_multi();
        test_loss();
        test_ignored();
        test_full_pop();
        test_reset();
        give_verdict();
    end
endmodule : event_timestamp_status_test

bind event_timestamp_status event_timestamp_status_chk #(.DEPTH(DEPTH)) chk_u (
    .clock(clock), .rst(rst), .clock_enable(clock_enable), .reg_read(reg_read), .reg_addr(reg_addr),
    .capture_valid(capture_valid), .capture_detected(capture_detected), .capture_rising(capture_rising),
    .capture_seconds(capture_seconds), .capture_nanoseconds(capture_nanoseconds),
    .read_data(read_data), .entry_pending(entry_pending));
